/* File: hdl/sspdh_pkg.sv */
// Constants, register map and carrier types of the synchronous serial port.
// Assumes a 24-bit register address space and an 8-bit register data path.
package sspdh_pkg;

   // ==========================================================
   // Register map
   localparam int ADDR_W = 24;
   localparam int DATA_W = 8;
   localparam logic [23:0] ADDR_HS_DIR = 24'hfffb80;
   localparam logic [23:0] ADDR_ICR = 24'hfffb91;
   localparam logic [23:0] ADDR_PORT1 = 24'hffff40;
   localparam logic [23:0] ADDR_PORT1_OUTPUT_DATA = 24'hffff50;
   localparam logic [23:0] ADDR_SMR = 24'hffff80;
   localparam logic [23:0] ADDR_BRR = 24'hffff81;
   localparam logic [23:0] ADDR_SCR = 24'hffff82;
   localparam logic [23:0] ADDR_TDR = 24'hffff83;
   localparam logic [23:0] ADDR_SSR = 24'hffff84;
   localparam logic [23:0] ADDR_RDR = 24'hffff85;
   localparam logic [23:0] ADDR_SCMR = 24'hffff86;

   // ==========================================================
   // Field positions
   localparam int SCR_TIE = 7;
   localparam int SCR_RIE = 6;
   localparam int SCR_TE = 5;
   localparam int SCR_RE = 4;
   localparam int SCR_TX_DONE_IRQ_EN = 2;
   localparam int SCR_SCK_SOURCE_HI = 1;
   localparam int SSR_TX_BUF_EMPTY = 7;
   localparam int SSR_RX_BUF_FULL = 6;
   localparam int SSR_OVERRUN_FLAG = 5;
   localparam int SSR_TX_COMPLETE = 2;
   localparam int SMR_CKS_LO = 0;
   localparam int SCMR_CARD_MODE_SEL = 0;
   localparam int HS_BIT = 3;
   localparam int ICR_RX = 1;
   localparam int ICR_CLK = 0;

   // ==========================================================
   // Reset values and counts
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] BRR_RST = 8'hff;
   localparam logic [7:0] READ_ZERO = 8'h00;
   localparam int CHAR_BITS = 8;
   localparam int CNT_W = $clog2(CHAR_BITS);
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(CHAR_BITS - 1);

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } sspdh_bus_req_t;

   typedef struct packed {
      logic tx_empty_irq;
      logic rx_full_irq;
      logic rx_error_irq;
      logic tx_end_irq;
   } sspdh_irq_t;

endpackage

/* File: hdl/sspdh_top.sv */
// Clock-synchronous serial port, slave end of an 8-bit point-to-point link,
// with status flags, interrupt request lines for a DMA engine and the
// handshake pin. Assumes one clock, a register port whose read data are
// taken one cycle after the read strobe, and pins that are asynchronous.
//
// Decided for this implementation: the address-and-strobe port.
module sspdh_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire sspdh_pkg::sspdh_bus_req_t bus_req,
   output logic [sspdh_pkg::DATA_W-1:0] rd_data,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   input wire logic serial_rx_pin,
   output logic tx_data_o,
   input wire logic hs_i,
   output logic hs_o,
   output logic hs_oe,
   output sspdh_pkg::sspdh_irq_t irq
);
   import sspdh_pkg::*;

   typedef enum {SSPDH_TX_IDLE, SSPDH_TX_SHIFT} sspdh_tx_state_t;

   // ==========================================================
   // Registers and decode
   logic [7:0] hs_dir_r, icr_r, port1_output_data_r, smr_r, brr_r, scr_r, scmr_r;
   logic [7:0] tdr_r, rdr_r, tsr_r, rsr_r, rsr_nxt;
   logic tx_buf_empty_r, rx_buf_full_r, overrun_flag_r, tx_complete_r;
   logic seen_tx_buf_empty_r, seen_rx_buf_full_r, seen_overrun_flag_r;
   logic sck_s1_r, sck_s2_r, rx_s1_r, rx_s2_r, hs_s1_r, hs_s2_r;
   logic sck_int_r, clk_prev_r;
   logic [15:0] div_cnt_r;
   logic [CNT_W-1:0] tx_cnt_r, rx_cnt_r;
   sspdh_tx_state_t tx_state_r;

   logic tx_on, rx_on, serial_ok, ext_clk;
   logic sck_seen, rx_bit, sel_clk, clk_rise, clk_fall;
   logic wr_scr, wr_tdr, wr_ssr, rd_ssr, rd_rdr;
   logic tx_load, char_end, dma_tdr_wr, dma_rdr_rd;
   logic tx_buf_empty_clr, rx_buf_full_clr, overrun_flag_clr, rx_shift_en, rx_done;
   logic run_int;

   function automatic logic [15:0] half_period(input logic [7:0] brr,
                                               input logic [1:0] cks);
      logic [15:0] base;
      base = {8'h00, brr} + 16'h0001;
      half_period = base << {cks, 1'b0};
   endfunction

   assign tx_on = scr_r[SCR_TE];
   assign rx_on = scr_r[SCR_RE];
   assign ext_clk = scr_r[SCR_SCK_SOURCE_HI];
   // card mode halts
   // Card interface operation is not built, so that setting stops the port.
   assign serial_ok = ~scmr_r[SCMR_CARD_MODE_SEL];

   assign wr_scr = bus_req.wr && (bus_req.addr == ADDR_SCR);
   assign wr_tdr = bus_req.wr && (bus_req.addr == ADDR_TDR);
   assign wr_ssr = bus_req.wr && (bus_req.addr == ADDR_SSR);
   assign rd_ssr = bus_req.rd && (bus_req.addr == ADDR_SSR);
   assign rd_rdr = bus_req.rd && (bus_req.addr == ADDR_RDR);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hs_dir_r <= REG_RST;
         icr_r <= REG_RST;
         port1_output_data_r <= REG_RST;
         smr_r <= REG_RST;
         brr_r <= BRR_RST;
         scr_r <= REG_RST;
         scmr_r <= REG_RST;
         tdr_r <= REG_RST;
      end else if (bus_req.wr) begin
         if (bus_req.addr == ADDR_HS_DIR) begin
            hs_dir_r <= bus_req.wdata;
         end else if (bus_req.addr == ADDR_ICR) begin
            icr_r <= bus_req.wdata;
         end else if (bus_req.addr == ADDR_PORT1_OUTPUT_DATA) begin
            port1_output_data_r <= bus_req.wdata;
         end else if (bus_req.addr == ADDR_SMR) begin
            smr_r <= bus_req.wdata;
         end else if (bus_req.addr == ADDR_BRR) begin
            brr_r <= bus_req.wdata;
         end else if (bus_req.addr == ADDR_SCR) begin
            scr_r <= bus_req.wdata;
         end else if (bus_req.addr == ADDR_SCMR) begin
            scmr_r <= bus_req.wdata;
         end else if (bus_req.addr == ADDR_TDR) begin
            tdr_r <= bus_req.wdata;
         end
      end
   end

   // The direction register is write only and reads back as zero.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data <= READ_ZERO;
      end else if (bus_req.rd) begin
         rd_data <= READ_ZERO;
         if (bus_req.addr == ADDR_ICR) begin
            rd_data <= icr_r;
         end else if (bus_req.addr == ADDR_PORT1) begin
            rd_data[HS_BIT] <= hs_s2_r;
         end else if (bus_req.addr == ADDR_PORT1_OUTPUT_DATA) begin
            rd_data <= port1_output_data_r;
         end else if (bus_req.addr == ADDR_SMR) begin
            rd_data <= smr_r;
         end else if (bus_req.addr == ADDR_BRR) begin
            rd_data <= brr_r;
         end else if (bus_req.addr == ADDR_SCR) begin
            rd_data <= scr_r;
         end else if (bus_req.addr == ADDR_TDR) begin
            rd_data <= tdr_r;
         end else if (bus_req.addr == ADDR_SSR) begin
            rd_data[SSR_TX_BUF_EMPTY] <= tx_buf_empty_r;
            rd_data[SSR_RX_BUF_FULL] <= rx_buf_full_r;
            rd_data[SSR_OVERRUN_FLAG] <= overrun_flag_r;
            rd_data[SSR_TX_COMPLETE] <= tx_complete_r;
         end else if (bus_req.addr == ADDR_RDR) begin
            rd_data <= rdr_r;
         end else if (bus_req.addr == ADDR_SCMR) begin
            rd_data <= scmr_r;
         end
      end
   end

   // ==========================================================
   // Pins and serial clock
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sck_s1_r <= 1'b1;
         sck_s2_r <= 1'b1;
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
         hs_s1_r <= 1'b0;
         hs_s2_r <= 1'b0;
      end else begin
         sck_s1_r <= sck_i;
         sck_s2_r <= sck_s1_r;
         rx_s1_r <= serial_rx_pin;
         rx_s2_r <= rx_s1_r;
         hs_s1_r <= hs_i;
         hs_s2_r <= hs_s1_r;
      end
   end

   assign sck_seen = icr_r[ICR_CLK] ? sck_s2_r : 1'b1;
   assign rx_bit = icr_r[ICR_RX] ? rx_s2_r : 1'b1;

   // The internal clock only runs while there is work, idling high.
   assign run_int = serial_ok & ~ext_clk &
                    ((tx_state_r == SSPDH_TX_SHIFT) | (rx_on & ~tx_on));

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_cnt_r <= 16'h0000;
         sck_int_r <= 1'b1;
      end else if (!run_int) begin
         div_cnt_r <= 16'h0000;
         sck_int_r <= 1'b1;
      end else if (div_cnt_r + 16'h0001 >=
                   half_period(brr_r, smr_r[SMR_CKS_LO +: 2])) begin
         div_cnt_r <= 16'h0000;
         sck_int_r <= ~sck_int_r;
      end else begin
         div_cnt_r <= div_cnt_r + 16'h0001;
      end
   end

   assign sel_clk = ext_clk ? sck_seen : sck_int_r;
   assign clk_rise = sel_clk & ~clk_prev_r;
   assign clk_fall = ~sel_clk & clk_prev_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clk_prev_r <= 1'b1;
         sck_o <= 1'b1;
         sck_oe <= 1'b0;
      end else begin
         clk_prev_r <= sel_clk;
         sck_o <= sck_int_r;
         sck_oe <= ~ext_clk & serial_ok;
      end
   end

   assign hs_o = port1_output_data_r[HS_BIT];
   assign hs_oe = hs_dir_r[HS_BIT];

   // ==========================================================
   // Transmitter
   assign char_end = (tx_state_r == SSPDH_TX_SHIFT) && clk_rise &&
                     (tx_cnt_r == LAST_BIT);
   assign tx_load = serial_ok & tx_on & ~tx_buf_empty_r &
                    ((tx_state_r == SSPDH_TX_IDLE) | char_end);

   // LSB first shifting
   // Data change on the falling edge so the master samples on the rising.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_state_r <= SSPDH_TX_IDLE;
         tsr_r <= REG_RST;
         tx_cnt_r <= '0;
         tx_data_o <= 1'b1;
      end else if (!tx_on || !serial_ok) begin
         tx_state_r <= SSPDH_TX_IDLE;
         tx_cnt_r <= '0;
         tx_data_o <= 1'b1;
      end else begin
         case (tx_state_r)
            SSPDH_TX_IDLE: begin
               if (tx_load) begin
                  tsr_r <= tdr_r;
                  tx_cnt_r <= '0;
                  tx_state_r <= SSPDH_TX_SHIFT;
               end
            end
            SSPDH_TX_SHIFT: begin
               if (tx_load) begin
                  tsr_r <= tdr_r;
                  tx_cnt_r <= '0;
               end else if (char_end) begin
                  tx_state_r <= SSPDH_TX_IDLE;
               end else if (clk_fall) begin
                  tx_data_o <= tsr_r[0];
                  tsr_r <= {1'b0, tsr_r[CHAR_BITS-1:1]};
               end else if (clk_rise) begin
                  tx_cnt_r <= tx_cnt_r + 1'b1;
               end
            end
            default: tx_state_r <= SSPDH_TX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Receiver
   assign rx_shift_en = serial_ok & rx_on & clk_rise;
   assign rx_done = rx_shift_en & (rx_cnt_r == LAST_BIT);
   assign rsr_nxt = {rx_bit, rsr_r[CHAR_BITS-1:1]};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rsr_r <= REG_RST;
         rx_cnt_r <= '0;
      end else if (!rx_on) begin
         rx_cnt_r <= '0;
      end else if (rx_shift_en) begin
         rsr_r <= rsr_nxt;
         rx_cnt_r <= rx_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdr_r <= REG_RST;
      end else if (rx_done && !rx_buf_full_r) begin
         rdr_r <= rsr_nxt;
      end
   end

   // ==========================================================
   // Status flags
   // A flag is only cleared by a zero write once software has read it as
   // one; a status write forgets every earlier read.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         seen_tx_buf_empty_r <= 1'b0;
         seen_rx_buf_full_r <= 1'b0;
         seen_overrun_flag_r <= 1'b0;
      end else if (rd_ssr) begin
         seen_tx_buf_empty_r <= tx_buf_empty_r;
         seen_rx_buf_full_r <= rx_buf_full_r;
         seen_overrun_flag_r <= overrun_flag_r;
      end else if (wr_ssr) begin
         seen_tx_buf_empty_r <= 1'b0;
         seen_rx_buf_full_r <= 1'b0;
         seen_overrun_flag_r <= 1'b0;
      end
   end

   assign tx_buf_empty_clr = (wr_ssr & ~bus_req.wdata[SSR_TX_BUF_EMPTY] & seen_tx_buf_empty_r) |
                     dma_tdr_wr;
   assign rx_buf_full_clr = (wr_ssr & ~bus_req.wdata[SSR_RX_BUF_FULL] & seen_rx_buf_full_r) |
                     dma_rdr_rd;
   assign overrun_flag_clr = wr_ssr & ~bus_req.wdata[SSR_OVERRUN_FLAG] & seen_overrun_flag_r;
   assign dma_tdr_wr = wr_tdr & irq.tx_empty_irq;
   assign dma_rdr_rd = rd_rdr & irq.rx_full_irq;

   // Every setting condition wins over a clear in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_buf_empty_r <= 1'b1;
         tx_complete_r <= 1'b1;
      end else begin
         if (tx_load || !tx_on) begin
            tx_buf_empty_r <= 1'b1;
         end else if (tx_buf_empty_clr) begin
            tx_buf_empty_r <= 1'b0;
         end
         if (!tx_on || (char_end && tx_buf_empty_r)) begin
            tx_complete_r <= 1'b1;
         end else if (tx_buf_empty_clr) begin
            tx_complete_r <= 1'b0;
         end
      end
   end

   // Receive disable does not touch either receive flag.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_buf_full_r <= 1'b0;
         overrun_flag_r <= 1'b0;
      end else begin
         if (rx_done && !rx_buf_full_r) begin
            rx_buf_full_r <= 1'b1;
         end else if (rx_buf_full_clr) begin
            rx_buf_full_r <= 1'b0;
         end
         if (rx_done && rx_buf_full_r) begin
            overrun_flag_r <= 1'b1;
         end else if (overrun_flag_clr) begin
            overrun_flag_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Request lines
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq <= '0;
      end else begin
         irq.tx_empty_irq <= scr_r[SCR_TIE] & tx_buf_empty_r & tx_on;
         irq.rx_full_irq <= scr_r[SCR_RIE] & rx_buf_full_r;
         irq.rx_error_irq <= scr_r[SCR_RIE] & overrun_flag_r;
         irq.tx_end_irq <= scr_r[SCR_TX_DONE_IRQ_EN] & tx_complete_r;
      end
   end

   // ==========================================================
   // Checks
   property p_tx_buf_empty_load;
      @(posedge ref_clk) disable iff (rst)
      tx_load |=> tx_buf_empty_r && (tsr_r == $past(tdr_r));
   endproperty
   a_tx_buf_empty_load: assert property (p_tx_buf_empty_load)
      else $error("empty flag not set on load");

   property p_tx_buf_empty_dma;
      @(posedge ref_clk) disable iff (rst)
      (dma_tdr_wr && tx_on && !wr_scr) |=> !tx_buf_empty_r && !tx_complete_r;
   endproperty
   a_tx_buf_empty_dma: assert property (p_tx_buf_empty_dma)
      else $error("DMA write did not clear empty flag");

   property p_rx_buf_full_set;
      @(posedge ref_clk) disable iff (rst)
      (rx_done && !rx_buf_full_r) |=> rx_buf_full_r && (rdr_r == $past(rsr_nxt));
   endproperty
   a_rx_buf_full_set: assert property (p_rx_buf_full_set)
      else $error("received byte not latched");

   property p_rx_buf_full_hold;
      @(posedge ref_clk) disable iff (rst)
      (rx_buf_full_r && !rx_buf_full_clr) |=> rx_buf_full_r;
   endproperty
   a_rx_buf_full_hold: assert property (p_rx_buf_full_hold)
      else $error("full flag dropped without clear");

   property p_overrun;
      @(posedge ref_clk) disable iff (rst)
      (rx_done && rx_buf_full_r) |=> overrun_flag_r && $stable(rdr_r);
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged or byte kept");

   property p_w1_none;
      @(posedge ref_clk) disable iff (rst)
      (wr_ssr && bus_req.wdata[SSR_OVERRUN_FLAG] && overrun_flag_r) |=> overrun_flag_r;
   endproperty
   a_w1_none: assert property (p_w1_none)
      else $error("writing one changed overrun flag");

   property p_tx_complete_set;
      @(posedge ref_clk) disable iff (rst)
      (char_end && tx_buf_empty_r && tx_on) |=> tx_complete_r ##1 irq.tx_end_irq ||
                                         !scr_r[SCR_TX_DONE_IRQ_EN];
   endproperty
   a_tx_complete_set: assert property (p_tx_complete_set)
      else $error("transmit end not set");

   property p_rx_gate;
      @(posedge ref_clk) disable iff (rst)
      !scr_r[SCR_RIE] [*2] |-> !irq.rx_full_irq && !irq.rx_error_irq;
   endproperty
   a_rx_gate: assert property (p_rx_gate)
      else $error("receive request not gated");

   property p_no_drive;
      @(posedge ref_clk) disable iff (rst)
      ext_clk |=> !sck_oe;
   endproperty
   a_no_drive: assert property (p_no_drive)
      else $error("clock pin driven in external mode");

   property p_rx_fixed;
      @(posedge ref_clk) disable iff (rst)
      (rx_shift_en && !icr_r[ICR_RX]) |=> rsr_r[CHAR_BITS-1];
   endproperty
   a_rx_fixed: assert property (p_rx_fixed)
      else $error("disabled receive buffer not high");

endmodule // sspdh_top

/* File: test/sspdh_master_model.sv */
// Behavioural master end of the serial link. It supplies the serial clock,
// drives receive data and samples the slave's transmit data.
// Assumes the slave samples data on rising clock edges and changes its
// transmit bit a few cycles after each falling edge.
module sspdh_master_model (
   input wire logic ref_clk,
   input wire logic hs_line,
   input wire logic tx_line,
   output logic sck_m,
   output logic mosi
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sck_m = 1'b1;
      mosi = 1'b1;
   end

   // ==========================================================
   // One byte each way
   // The clock stands high between frames.
   task automatic xfer(input logic [7:0] d, input int half,
                       output logic [7:0] got);
      int n;
      n = 0;
      while (hs_line !== 1'b1 && n < 1000) begin
         @(posedge ref_clk);
         n++;
      end
      for (int i = 0; i < 8; i++) begin
         repeat (half) @(posedge ref_clk);
         sck_m <= 1'b0;
         mosi <= d[i];
         repeat (half) @(posedge ref_clk);
         sck_m <= 1'b1;
         got[i] = tx_line;
      end
      // A released line shows the inverse, so a stale level cannot pass.
      repeat (half) @(posedge ref_clk);
      mosi <= ~d[7];
   endtask
endmodule // sspdh_master_model

/* File: test/sspdh_top_tb.sv */
// Self-checking bench of the synchronous serial port, slave end.
// Assumes the master model drives the clock pin while the port takes an
// external clock, and that the handshake line has a pull-down.
module sspdh_top_tb;
   import sspdh_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int LIMIT = 20000;
   logic ref_clk;
   logic rst;
   sspdh_bus_req_t bus_req;
   logic [7:0] rd_data;
   logic sck_o, sck_oe, tx_data_o, hs_o, hs_oe, sck_m, mosi;
   sspdh_irq_t irq;
   wire logic sck_pin = sck_oe ? sck_o : sck_m;
   wire logic hs_pin = hs_oe ? hs_o : 1'b0;
   int fails, compares, cycles;
   logic [7:0] got;
   logic s0;

   sspdh_top uut (
      .ref_clk(ref_clk),
      .rst(rst),
      .bus_req(bus_req),
      .rd_data(rd_data),
      .sck_i(sck_pin),
      .sck_o(sck_o),
      .sck_oe(sck_oe),
      .serial_rx_pin(mosi),
      .tx_data_o(tx_data_o),
      .hs_i(hs_pin),
      .hs_o(hs_o),
      .hs_oe(hs_oe),
      .irq(irq)
   );

   sspdh_master_model master (
      .ref_clk(ref_clk),
      .hs_line(hs_pin),
      .tx_line(tx_data_o),
      .sck_m(sck_m),
      .mosi(mosi)
   );

   always #2 ref_clk = ~ref_clk;

   // ==========================================================
   // Checking and bus tasks
   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
   endtask

   // Read data appear in the cycle after the strobe and hold until the next read.
   task automatic rdchk(input string what, input logic [23:0] a,
                        input logic [7:0] exp);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1;
      chk(what, rd_data, exp);
   endtask

   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // A hang is cut short and reported as a mismatch.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         give_verdict();
      end
   end

   // ==========================================================
   // Tests
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      bus_req = '0;
      fails = 0;
      compares = 0;
      cycles = 0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rdchk("status reset", ADDR_SSR, 8'h84);
      rdchk("control reset", ADDR_SCR, 8'h00);
      rdchk("card mode", ADDR_SCMR, 8'h00);
      rdchk("bit rate", ADDR_BRR, 8'hff);
      rdchk("unmapped", 24'hffff8f, 8'h00);
      wr(ADDR_SMR, 8'h03);
      rdchk("prescale", ADDR_SMR, 8'h03);
      $display("test reset and map done");

      wr(ADDR_ICR, 8'h03);
      wr(ADDR_HS_DIR, 8'h08);
      wr(ADDR_PORT1_OUTPUT_DATA, 8'h08);
      wr(ADDR_SCR, 8'h30);
      settle();
      chk("clock driven", {7'h0, sck_oe}, 8'h01);
      wr(ADDR_SCR, 8'h32);
      settle();
      chk("clock taken", {7'h0, sck_oe}, 8'h00);
      chk("hs enable", {7'h0, hs_oe}, 8'h01);
      chk("hs level", {7'h0, hs_o}, 8'h01);
      rdchk("dir write only", ADDR_HS_DIR, 8'h00);
      rdchk("hs pin", ADDR_PORT1, 8'h08);
      $display("test configuration done");

      wr(ADDR_SCR, 8'hb6);
      settle();
      chk("tx empty irq", {7'h0, irq.tx_empty_irq}, 8'h01);
      chk("tx end irq", {7'h0, irq.tx_end_irq}, 8'h01);
      wr(ADDR_TDR, 8'ha5);
      settle();
      rdchk("after load", ADDR_SSR, 8'h80);
      wr(ADDR_SCR, 8'h36);
      settle();
      chk("tx empty gated", {7'h0, irq.tx_empty_irq}, 8'h00);
      chk("tx end low", {7'h0, irq.tx_end_irq}, 8'h00);
      master.xfer(8'h3c, 8, got);
      settle();
      chk("tx byte", got, 8'ha5);
      chk("tx end irq", {7'h0, irq.tx_end_irq}, 8'h01);
      rdchk("after frame", ADDR_SSR, 8'hc4);
      wr(ADDR_SCR, 8'h32);
      settle();
      chk("tx end gated", {7'h0, irq.tx_end_irq}, 8'h00);
      $display("test transfer done");

      master.xfer(8'h5a, 12, got);
      settle();
      rdchk("overrun", ADDR_SSR, 8'he4);
      wr(ADDR_SSR, 8'hff);
      wr(ADDR_SSR, 8'h00);
      rdchk("no clear", ADDR_SSR, 8'he4);
      wr(ADDR_SCR, 8'h22);
      rdchk("rx off keeps", ADDR_SSR, 8'he4);
      wr(ADDR_SCR, 8'h72);
      settle();
      chk("rx full irq", {7'h0, irq.rx_full_irq}, 8'h01);
      chk("rx error irq", {7'h0, irq.rx_error_irq}, 8'h01);
      rdchk("first kept", ADDR_RDR, 8'h3c);
      settle();
      rdchk("dma read", ADDR_SSR, 8'ha4);
      wr(ADDR_SSR, 8'hdf);
      rdchk("overrun clear", ADDR_SSR, 8'h84);
      $display("test overrun done");

      wr(ADDR_SCR, 8'hb6);
      wr(ADDR_TDR, 8'h11);
      settle();
      wr(ADDR_SCR, 8'h16);
      settle();
      rdchk("tx disable", ADDR_SSR, 8'h84);
      $display("test disable done");

      wr(ADDR_ICR, 8'h01);
      wr(ADDR_SCR, 8'h72);
      master.xfer(8'h00, 8, got);
      settle();
      rdchk("rx buffer off", ADDR_RDR, 8'hff);
      wr(ADDR_ICR, 8'h02);
      settle();
      master.xfer(8'h55, 8, got);
      settle();
      chk("clock buffer off", {7'h0, irq.rx_full_irq}, 8'h00);
      $display("test pin buffers done");

      // With prescale code zero and a bit rate of one, the internal clock
      // pin flips every second cycle while the port only receives.
      wr(ADDR_SMR, 8'h00);
      wr(ADDR_BRR, 8'h01);
      wr(ADDR_SCR, 8'h10);
      settle();
      chk("internal drive", {7'h0, sck_oe}, 8'h01);
      s0 = sck_o;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("undivided clock", {7'h0, sck_o}, {7'h0, ~s0});
      wr(ADDR_SCMR, 8'h01);
      settle();
      chk("card mode stops", {7'h0, sck_oe}, 8'h00);
      chk("card mode idle", {7'h0, sck_o}, 8'h01);
      $display("test internal clock done");
      give_verdict();
   end
endmodule // sspdh_top_tb
